/* shared/lssp_regs.vh */
// Constants for the shared indicator and strap pin block
`ifndef LSSP_REGS_VH
`define LSSP_REGS_VH
// Avalon register word byte addresses
`define LSSP_ADDR_CTRL 4'h0
`define LSSP_ADDR_STRAP 4'h4
`define LSSP_ADDR_LEDA 4'h8
`define LSSP_ADDR_LEDB 4'hC
// Control register field positions
`define LSSP_CTRL_LED_EN 0
`define LSSP_CTRL_SWP_EN 1
`define LSSP_CTRL_GANG_EN 2
`define LSSP_CTRL_BOOST_EN 3
// Control register reset value
`define LSSP_CTRL_RST 4'h0
// Strap register field positions
`define LSSP_STRAP_SWP_LSB 0
`define LSSP_STRAP_GANG 7
`define LSSP_STRAP_BOOST_LSB 8
// Read data for unmapped addresses
`define LSSP_UNMAPPED 32'h00000000
`endif

/* core/lssp_pin_cell.v */
// One shared pin: strap capture, polarity and output enable
`timescale 1ns/100ps
module lssp_pin_cell (
  // Clock and control
  input wire sys_clk_in,
  input wire ce_in,
  input wire capture_in,
  input wire strap_en_in,
  input wire led_en_in,
  input wire led_on_in,
  // Synchronised pin level
  input wire pin_sync_in,
  // Results
  output reg strap_q,
  output reg pin_o_q,
  output reg pin_oe_q
);

  always @(posedge sys_clk_in) begin
    if (ce_in) begin
      if (capture_in) begin
        strap_q <= strap_en_in & pin_sync_in;
      end
    end
  end

  always @(posedge sys_clk_in) begin
    if (ce_in) begin
      if (capture_in) begin
        pin_oe_q <= 1'b0;
        pin_o_q <= 1'b0;
      end else begin
        pin_oe_q <= led_en_in;
        pin_o_q <= led_on_in ^ strap_q;
      end
    end
  end

endmodule // lssp_pin_cell

/* core/lssp_top.v */
// Shared indicator/strap pins with Avalon-MM control
`timescale 1ns/100ps
`include "lssp_regs.vh"
module lssp_top #(
  parameter NPORT = 7
) (
  // Clock, reset, enable
  input wire sys_clk_in,
  input wire rst_n_in,
  input wire ce_in,
  // Avalon-MM slave
  input wire [3:0] avs_address_in,
  input wire avs_read_in,
  input wire avs_write_in,
  input wire [31:0] avs_writedata_in,
  input wire [3:0] avs_byteenable_in,
  output reg [31:0] avs_readdata_out,
  output reg avs_waitrequest_n_out,
  // Port indicator pins
  input wire [NPORT-1:0] port_indicator_n_in,
  output wire [NPORT-1:0] port_indicator_n_out,
  output wire [NPORT-1:0] port_indicator_n_oe_out,
  // Enhanced indicator pins, ports 1..7
  input wire [NPORT-1:0] enh_indicator_n_in,
  output wire [NPORT-1:0] enh_indicator_n_out,
  output wire [NPORT-1:0] enh_indicator_n_oe_out,
  // Captured strap results
  output reg [NPORT-1:0] polarity_swap_strap_out,
  output reg gang_mode_out,
  output reg [1:0] phy_current_field_out
);

  // Control word width and first always-low enhanced port
  localparam CTRL_W = 4;
  localparam ENH_LOW_FIRST = 3;

  reg [CTRL_W-1:0] ctrl_q;
  reg [NPORT-1:0] leda_on_q;
  reg [NPORT-1:0] ledb_on_q;
  reg [2*NPORT-1:0] meta_q;
  reg [2*NPORT-1:0] sync_q;
  reg rst_seen_q;
  reg capture_q;
  wire [NPORT-1:0] swp_w;
  wire [NPORT-1:0] enhs_w;
  wire [NPORT-1:0] enh_strap_en_w;
  wire [NPORT-1:0] enh_on_w;
  wire [31:0] strap_word_w;
  wire avs_req_w;
  wire avs_hit_w;
  wire avs_wr_w;
  wire wr_ctrl_w;
  wire wr_leda_w;
  wire wr_ledb_w;
  genvar i;

  // Zero-extend a per-port mask to a bus word
  function [31:0] lssp_mask_word;
    input [NPORT-1:0] mask;
    begin
      lssp_mask_word = {{(32-NPORT){1'b0}}, mask};
    end
  endfunction

  // Compare the bus address with one register word
  function lssp_addr_is;
    input [3:0] addr;
    input [3:0] reg_addr;
    begin
      lssp_addr_is = (addr == reg_addr);
    end
  endfunction

  // A request is taken at the edge where waitrequest_n stands high
  assign avs_req_w = avs_read_in | avs_write_in;
  assign avs_hit_w = avs_req_w & avs_waitrequest_n_out;

  // Write strobes; byte lane 0 must be enabled
  assign avs_wr_w = avs_hit_w & avs_write_in & avs_byteenable_in[0];
  assign wr_ctrl_w = avs_wr_w & lssp_addr_is(avs_address_in, `LSSP_ADDR_CTRL);
  assign wr_leda_w = avs_wr_w & lssp_addr_is(avs_address_in, `LSSP_ADDR_LEDA);
  assign wr_ledb_w = avs_wr_w & lssp_addr_is(avs_address_in, `LSSP_ADDR_LEDB);

  // Pin synchronisers, two flops
  always @(posedge sys_clk_in) begin
    if (ce_in) begin
      meta_q <= {enh_indicator_n_in, port_indicator_n_in};
      sync_q <= meta_q;
    end
  end

  // one-cycle capture strobe on reset negation
  always @(posedge sys_clk_in) begin
    if (ce_in) begin
      if (!rst_n_in) begin
        rst_seen_q <= 1'b1;
        capture_q <= 1'b0;
      end else begin
        rst_seen_q <= 1'b0;
        capture_q <= rst_seen_q;
      end
    end
  end

  // ports 1-3 enhanced straps enabled by mode
  assign enh_strap_en_w = {{(NPORT-3){1'b0}}, ctrl_q[`LSSP_CTRL_GANG_EN],
    {2{ctrl_q[`LSSP_CTRL_BOOST_EN]}}};

  // ports 4-7 enhanced indicators active low
  generate
    for (i = 0; i < NPORT; i = i + 1) begin : g_enh_pol
      if (i >= ENH_LOW_FIRST) begin : g_low
        assign enh_on_w[i] = ~ledb_on_q[i];
      end else begin : g_strap
        assign enh_on_w[i] = ledb_on_q[i];
      end
    end
  endgenerate

  generate
    for (i = 0; i < NPORT; i = i + 1) begin : g_pin
      lssp_pin_cell u_a (
        .sys_clk_in(sys_clk_in),
        .ce_in(ce_in),
        .capture_in(capture_q | ~rst_n_in),
        .strap_en_in(ctrl_q[`LSSP_CTRL_SWP_EN]),
        .led_en_in(ctrl_q[`LSSP_CTRL_LED_EN]),
        .led_on_in(leda_on_q[i]),
        .pin_sync_in(sync_q[i]),
        .strap_q(swp_w[i]),
        .pin_o_q(port_indicator_n_out[i]),
        .pin_oe_q(port_indicator_n_oe_out[i])
      );
      // enhanced cells, straps only on ports 1-3
      lssp_pin_cell u_b (
        .sys_clk_in(sys_clk_in),
        .ce_in(ce_in),
        .capture_in(capture_q | ~rst_n_in),
        .strap_en_in(enh_strap_en_w[i]),
        .led_en_in(ctrl_q[`LSSP_CTRL_LED_EN]),
        .led_on_in(enh_on_w[i]),
        .pin_sync_in(sync_q[NPORT+i]),
        .strap_q(enhs_w[i]),
        .pin_o_q(enh_indicator_n_out[i]),
        .pin_oe_q(enh_indicator_n_oe_out[i])
      );
    end
  endgenerate

  // strap outputs follow held cell values
  always @(posedge sys_clk_in) begin
    if (ce_in) begin
      polarity_swap_strap_out <= swp_w;
      gang_mode_out <= enhs_w[2];
      // boost field, bit1 port 2, bit0 port 1
      phy_current_field_out <= {enhs_w[1], enhs_w[0]};
    end
  end

  // Strap word: swap bits, gang bit, boost field
  assign strap_word_w = {
    {(32-2-NPORT-1){1'b0}},
    enhs_w[1:0],
    gang_mode_out,
    swp_w
  };

  // Register writes; reset clears control and both LED masks
  always @(posedge sys_clk_in) begin
    if (!rst_n_in) begin
      ctrl_q <= `LSSP_CTRL_RST;
      leda_on_q <= {NPORT{1'b0}};
      ledb_on_q <= {NPORT{1'b0}};
    end else if (ce_in) begin
      if (wr_ctrl_w) begin
        ctrl_q <= avs_writedata_in[CTRL_W-1:0];
      end
      if (wr_leda_w) begin
        leda_on_q <= avs_writedata_in[NPORT-1:0];
      end
      if (wr_ledb_w) begin
        ledb_on_q <= avs_writedata_in[NPORT-1:0];
      end
    end
  end

  // Read answer and one wait cycle per access
  always @(posedge sys_clk_in) begin
    if (!rst_n_in) begin
      avs_waitrequest_n_out <= 1'b0;
      avs_readdata_out <= 32'h00000000;
    end else if (ce_in) begin
      avs_waitrequest_n_out <= avs_req_w & ~avs_waitrequest_n_out;
      case (avs_address_in)
        `LSSP_ADDR_CTRL: avs_readdata_out <= {28'h0000000, ctrl_q};
        `LSSP_ADDR_STRAP: avs_readdata_out <= strap_word_w;
        `LSSP_ADDR_LEDA: avs_readdata_out <= lssp_mask_word(leda_on_q);
        `LSSP_ADDR_LEDB: avs_readdata_out <= lssp_mask_word(ledb_on_q);
        default: avs_readdata_out <= `LSSP_UNMAPPED;
      endcase
    end
  end

endmodule // lssp_top

/* verification/lssp_assertions.sv */
// Checker for the shared indicator and strap pin block
`timescale 1ns/100ps
module lssp_checker #(parameter NPORT = 7) (
  // Clock and bus
  input wire sys_clk_in,
  input wire rst_n_in,
  input wire avs_read_in,
  input wire avs_write_in,
  input wire avs_waitrequest_n_out,
  // Pins and straps
  input wire [NPORT-1:0] port_indicator_n_oe_out,
  input wire [NPORT-1:0] enh_indicator_n_oe_out,
  input wire [NPORT-1:0] polarity_swap_strap_out,
  input wire gang_mode_out,
  input wire [1:0] phy_current_field_out
);
  default clocking cb @(posedge sys_clk_in); endclocking
  default disable iff (!rst_n_in);
  // Pending bus request
  sequence req_s;
    (avs_read_in || avs_write_in) && !avs_waitrequest_n_out;
  endsequence
  AST_ANS: assert property (req_s |=> avs_waitrequest_n_out) else $error("late answer");
  AST_ONE: assert property (avs_waitrequest_n_out |=> !avs_waitrequest_n_out) else $error("long answer");
  AST_NOREQ: assert property (!(avs_read_in || avs_write_in) |=> !avs_waitrequest_n_out)
    else $error("answer without request");
  AST_CAP: assert property ($rose(rst_n_in) |-> ##2 polarity_swap_strap_out == 0 && !gang_mode_out)
    else $error("strap captured while disabled");
  AST_HOLD: assert property ($past(rst_n_in, 4) |-> $stable(polarity_swap_strap_out))
    else $error("strap changed");
  AST_MODE: assert property ($past(rst_n_in, 4) |-> $stable({gang_mode_out, phy_current_field_out}))
    else $error("mode strap changed");
  AST_RST_OE: assert property (disable iff (1'b0) !rst_n_in |=> port_indicator_n_oe_out == 0)
    else $error("pin driven in reset");
  AST_OE_EN: assert property (port_indicator_n_oe_out == enh_indicator_n_oe_out)
    else $error("drive enables differ");
endmodule // lssp_checker

/* verification/lssp_pin_model.sv */
// Indicator LEDs and strap resistors on the shared pins
`timescale 1ns/100ps
module lssp_pin_model #(parameter [6:0] PULL_A = 7'h55, parameter [6:0] PULL_B = 7'h2A) (
  // Drive from the block
  input wire [6:0] a_o_in,
  input wire [6:0] a_oe_in,
  input wire [6:0] b_o_in,
  input wire [6:0] b_oe_in,
  // Pin levels
  output wire [6:0] a_lvl_out,
  output wire [6:0] b_lvl_out
);
  // Undriven pins rest at the strap resistor level
  assign a_lvl_out = (a_oe_in & a_o_in) | (~a_oe_in & PULL_A);
  assign b_lvl_out = (b_oe_in & b_o_in) | (~b_oe_in & PULL_B);
endmodule // lssp_pin_model

/* verification/test_led_strap_shared_pins.sv */
// Self-checking bench for the shared indicator and strap pin block
`timescale 1ns/100ps
`include "lssp_regs.vh"
module test_led_strap_shared_pins;
  logic sys_clk_in = 1'h0, rst_n_in = 1'h0, ce_in = 1'h1, avs_read_in = 1'h0, avs_write_in = 1'h0;
  logic [3:0] avs_address_in = 4'h0, avs_byteenable_in = 4'hF;
  logic [31:0] avs_writedata_in = 32'h0, avs_readdata_out, rdata;
  logic avs_waitrequest_n_out, gang_mode_out;
  logic [1:0] phy_current_field_out;
  logic [6:0] pa_i, pa_o, pa_oe, pb_i, pb_o, pb_oe, polarity_swap_strap_out;
  integer err_count = 0, num_checks = 0;
  // Clock
  always #2.5 sys_clk_in = ~sys_clk_in;
  // Block and its pins
  lssp_top u_dut (.sys_clk_in, .rst_n_in, .ce_in, .avs_address_in, .avs_read_in,
    .avs_write_in, .avs_writedata_in, .avs_byteenable_in, .avs_readdata_out,
    .avs_waitrequest_n_out, .port_indicator_n_in(pa_i), .port_indicator_n_out(pa_o),
    .port_indicator_n_oe_out(pa_oe), .enh_indicator_n_in(pb_i), .enh_indicator_n_out(pb_o),
    .enh_indicator_n_oe_out(pb_oe), .polarity_swap_strap_out, .gang_mode_out,
    .phy_current_field_out);
  lssp_pin_model u_pins (.a_o_in(pa_o), .a_oe_in(pa_oe), .b_o_in(pb_o), .b_oe_in(pb_oe),
    .a_lvl_out(pa_i), .b_lvl_out(pb_i));
  task finish_test;
    if (err_count == 0 && num_checks > 0) $display("Regression OK");
    else $display("Regression broken");
    $finish;
  endtask
  task chk(input [31:0] got, input [31:0] exp);
    num_checks = num_checks + 1;
    if (got !== exp) begin
      err_count = err_count + 1;
      $display("unexpected t=%0t got %h exp %h", $time, got, exp);
    end
  endtask
  // One bus access, held until the answer
  task bus(input w, input [3:0] a, input [31:0] d, input [3:0] b);
    integer n;
    n = 0;
    avs_address_in <= a;
    avs_writedata_in <= d;
    avs_byteenable_in <= b;
    avs_write_in <= w;
    avs_read_in <= !w;
    // Watch waitrequest_n between edges; the answer is taken at the next edge
    @(negedge sys_clk_in);
    while (avs_waitrequest_n_out !== 1'h1 && n < 20) begin
      @(negedge sys_clk_in);
      n = n + 1;
    end
    rdata = avs_readdata_out;
    @(posedge sys_clk_in);
    avs_read_in <= 1'h0;
    avs_write_in <= 1'h0;
    if (n == 20) begin
      err_count = err_count + 1;
      finish_test;
    end
    repeat (3) @(posedge sys_clk_in);
  endtask
  // Main sequence
  initial begin
    for (int r = 0; r < 2; r++) begin
      rst_n_in <= 1'h0;
      repeat (8) @(posedge sys_clk_in);
      rst_n_in <= 1'h1;
      repeat (3) @(posedge sys_clk_in);
      chk(pa_oe, 7'h0);
      bus(1'h0, `LSSP_ADDR_STRAP, 32'h0, 4'hF);
      chk(rdata, 32'h0);
      chk({gang_mode_out, phy_current_field_out}, 3'h0);
      bus(1'h1, `LSSP_ADDR_CTRL, 32'h1, 4'hF);
      bus(1'h1, `LSSP_ADDR_LEDA, 32'h7F, 4'hF);
      bus(1'h1, `LSSP_ADDR_LEDB, 32'h7F, 4'hF);
      bus(1'h0, `LSSP_ADDR_LEDA, 32'h0, 4'hF);
      chk(rdata, 32'h7F);
      chk(pa_oe, 7'h7F);
      chk(pa_o, 7'h7F);
      chk(pb_o, 7'h07);
      bus(1'h1, `LSSP_ADDR_LEDB, 32'h0, 4'hF);
      chk(pb_o, 7'h78);
      bus(1'h1, `LSSP_ADDR_CTRL, 32'h0, 4'hE);
      chk(pb_oe, 7'h7F);
      bus(1'h0, 4'h2, 32'h0, 4'hF);
      chk(rdata, 32'h0);
      bus(1'h1, `LSSP_ADDR_CTRL, 32'h0, 4'hF);
      chk(pa_oe, 7'h0);
    end
    finish_test;
  end
endmodule // test_led_strap_shared_pins
bind lssp_top lssp_checker #(.NPORT(NPORT)) u_chk (.sys_clk_in, .rst_n_in, .avs_read_in,
  .avs_write_in, .avs_waitrequest_n_out, .port_indicator_n_oe_out, .enh_indicator_n_oe_out,
  .polarity_swap_strap_out, .gang_mode_out, .phy_current_field_out);
